// ---- logic/wss_sequencer.sv ----
// Waveform sequence slot bank with APB register access and playback sequencer.
// Assumes an external effect engine that takes an identifier and reports done.
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
module wss_sequencer #(
  parameter int unsigned STEP_CYCLES = wss_pkg::DELAY_STEP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output wss_pkg::wss_effect_t effect,
  input wire logic effect_done,
  output logic idle_active,
  output logic seq_busy,
  output logic [2:0] cur_slot
);

  // Register index of the current access
  function automatic logic [5:0] reg_index(input logic [11:0] a);
    reg_index = a[7:2];
  endfunction : reg_index

  // True when the index falls in the eight slot registers
  function automatic logic is_slot(input logic [5:0] idx);
    is_slot = (idx >= wss_pkg::IDX_SLOT_FIRST) && (idx <= wss_pkg::IDX_SLOT_EIGHT);
  endfunction : is_slot

  // Bus-side decode
  logic [5:0] idx;
  logic aligned;
  logic mapped;
  logic wr_en;
  logic [2:0] bus_slot;

  // Repeat counts, packed two bits per slot, slot one lowest
  logic [7:0] repeat_low_reg;
  logic [7:0] repeat_high_reg;
  logic [15:0] repeat_all;
  logic [1:0] repeat_limit;

  // Playback engine state
  wss_pkg::wss_state_t state_reg;
  logic [2:0] slot_reg;
  logic [1:0] pass_reg;
  logic entry_done;
  logic start_req;
  logic abort_req;

  // Delay timing; the divider is wide enough for a full 10 ms step at pclk
  logic [6:0] wait_left_reg;
  logic [31:0] step_cnt_reg;
  logic step_tick;

  // Slot store read data, one cycle behind its address
  wss_pkg::wss_slot_t bus_rd;
  wss_pkg::wss_slot_t seq_rd;

  // Address decode; upper bits and byte offset must be zero
  assign idx = reg_index(paddr);
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:8] == 4'h0);
  assign mapped = aligned && (is_slot(idx) || idx == wss_pkg::IDX_CONTROL ||
                  idx == wss_pkg::IDX_REPEAT_LOW || idx == wss_pkg::IDX_REPEAT_HIGH);
  // Writes land only at the edge that completes the access phase
  assign wr_en = psel && penable && pwrite && mapped;
  assign bus_slot = 3'(idx - wss_pkg::IDX_SLOT_FIRST);
  // Every register answers at once: zero wait states
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Start ignored while busy, so a second write cannot restart mid-sequence
  // A write of both start and abort is taken as abort
  assign start_req = wr_en && idx == wss_pkg::IDX_CONTROL &&
                     pwdata[wss_pkg::CTRL_START_BIT] && state_reg == wss_pkg::ST_IDLE;
  assign abort_req = wr_en && idx == wss_pkg::IDX_CONTROL && pwdata[wss_pkg::CTRL_ABORT_BIT];

  // Slot store; bus and sequencer each own a read port, so bus reads never stall playback
  wss_slot_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .we(wr_en && is_slot(idx)),
    .waddr(bus_slot),
    .wdata(wss_pkg::wss_slot_t'(pwdata[7:0])),
    .raddr_bus(bus_slot),
    .rdata_bus(bus_rd),
    .raddr_seq(slot_reg),
    .rdata_seq(seq_rd)
  );

  // Repeat count registers, two bits per slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      repeat_low_reg <= wss_pkg::REPEAT_RESET;
      repeat_high_reg <= wss_pkg::REPEAT_RESET;
    end else if (wr_en && idx == wss_pkg::IDX_REPEAT_LOW) begin
      repeat_low_reg <= pwdata[7:0];
    end else if (wr_en && idx == wss_pkg::IDX_REPEAT_HIGH) begin
      repeat_high_reg <= pwdata[7:0];
    end
  end

  // Read mux; slot data is valid in the access phase because the address is set up a cycle early
  // Unmapped addresses read zero and raise pslverr instead
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && mapped) begin
      if (is_slot(idx)) begin
        prdata[7:0] = bus_rd;
      end else if (idx == wss_pkg::IDX_REPEAT_LOW) begin
        prdata[7:0] = repeat_low_reg;
      end else if (idx == wss_pkg::IDX_REPEAT_HIGH) begin
        prdata[7:0] = repeat_high_reg;
      end else begin
        prdata[wss_pkg::CTRL_BUSY_BIT] = seq_busy;
      end
    end
  end

  // Repeat count of the slot in play
  assign repeat_all = {repeat_high_reg, repeat_low_reg};
  assign repeat_limit = repeat_all[{slot_reg, 1'b0} +: 2];

  // 10 ms step divider, restarted on entry to each delay
  // Held at zero outside the wait state, so a count never carries over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt_reg <= 32'h0000_0000;
    end else if (state_reg != wss_pkg::ST_WAIT || step_tick) begin
      step_cnt_reg <= 32'h0000_0000;
    end else begin
      step_cnt_reg <= step_cnt_reg + 32'h0000_0001;
    end
  end
  assign step_tick = (step_cnt_reg == 32'(STEP_CYCLES - 1));

  // Entry finished: effect reported done, or delay fully counted out
  assign entry_done = (state_reg == wss_pkg::ST_PLAY && effect_done) ||
                      (state_reg == wss_pkg::ST_WAIT && wait_left_reg == 7'h00);

  // Playback state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= wss_pkg::ST_IDLE;
      slot_reg <= 3'h0;
      pass_reg <= 2'h0;
    end else if (abort_req) begin
      // Abort wins over every state; slot and pass are reloaded on the next start
      state_reg <= wss_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        wss_pkg::ST_IDLE: begin
          if (start_req) begin
            slot_reg <= 3'h0;
            pass_reg <= 2'h0;
            state_reg <= wss_pkg::ST_FETCH;
          end
        end
        wss_pkg::ST_FETCH: begin
          state_reg <= wss_pkg::ST_DECODE;
        end
        wss_pkg::ST_DECODE: begin
          // Whole byte zero is the stop marker; a delay of zero is not
          if (seq_rd == wss_pkg::SLOT_RESET) begin
            state_reg <= wss_pkg::ST_IDLE;
          end else if (seq_rd.delay_flag) begin
            state_reg <= wss_pkg::ST_WAIT;
          end else begin
            state_reg <= wss_pkg::ST_PLAY;
          end
        end
        wss_pkg::ST_PLAY, wss_pkg::ST_WAIT: begin
          // Repeats go back to decode, so the same slot replays without a fetch
          if (entry_done) begin
            if (pass_reg != repeat_limit) begin
              pass_reg <= pass_reg + 2'h1;
              state_reg <= wss_pkg::ST_DECODE;
            end else if (slot_reg == wss_pkg::SLOT_LAST) begin
              state_reg <= wss_pkg::ST_IDLE;
            end else begin
              pass_reg <= 2'h0;
              slot_reg <= slot_reg + 3'h1;
              state_reg <= wss_pkg::ST_FETCH;
            end
          end
        end
      endcase
    end
  end

  // Delay countdown, one step per tick
  // A field of zero still spends one cycle in the wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_left_reg <= 7'h00;
    end else if (state_reg == wss_pkg::ST_DECODE) begin
      wait_left_reg <= seq_rd.field;
    end else if (state_reg == wss_pkg::ST_WAIT && step_tick && wait_left_reg != 7'h00) begin
      wait_left_reg <= wait_left_reg - 7'h01;
    end
  end

  // Effect request toward the library; start pulses on entry to play
  // A stop marker or a pending abort must not launch the library
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      effect <= '0;
    end else begin
      effect.start <= state_reg == wss_pkg::ST_DECODE && seq_rd != wss_pkg::SLOT_RESET &&
                      !seq_rd.delay_flag && !abort_req;
      if (state_reg == wss_pkg::ST_DECODE && !seq_rd.delay_flag) begin
        effect.id <= seq_rd.field;
      end
    end
  end

  // Status straight from the state register, no extra latency
  assign idle_active = state_reg == wss_pkg::ST_WAIT;
  assign seq_busy = state_reg != wss_pkg::ST_IDLE;
  assign cur_slot = slot_reg;

endmodule : wss_sequencer

// ---- logic/wss_pkg.sv ----
// Constants, field layouts and carrier types for the waveform sequence slot bank.
// Assumes a single 10 MHz pclk and an APB master with 32-bit data.
// What this block does
// - Delay flag set: slot idles, no waveform
// - Delay lasts 10 ms times field value
// - Delay flag clear: field is effect identifier
// - Identifier bits 6..0 index effect library
// - Start bit begins playback at first slot
// - After effect ends, advance to next slot
// - Stop at zero entry or after slot eight
// - Zero entry halts sequencer when reached
// - Two-bit repeat count plays entry 1..4 times
package wss_pkg;

  // Printed register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONTROL = 6'h0c;
  localparam logic [5:0] IDX_SLOT_FIRST = 6'h0f;
  localparam logic [5:0] IDX_SLOT_SEVEN = 6'h15;
  localparam logic [5:0] IDX_SLOT_EIGHT = 6'h16;
  localparam logic [5:0] IDX_REPEAT_LOW = 6'h17;
  localparam logic [5:0] IDX_REPEAT_HIGH = 6'h18;

  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ABORT_BIT = 1;
  localparam int CTRL_BUSY_BIT = 0;

  // Slot layout and reset values
  localparam int SLOT_COUNT = 8;
  localparam logic [2:0] SLOT_LAST = 3'h7;
  localparam logic [7:0] SLOT_RESET = 8'h00;
  localparam logic [7:0] REPEAT_RESET = 8'h00;

  // Delay step timing
  localparam int DELAY_STEP_MS = 10;
  localparam int CLK_HZ = 10000000;
  localparam int DELAY_STEP_CYCLES = (CLK_HZ / 1000) * DELAY_STEP_MS;

  typedef struct packed {
    logic delay_flag;
    logic [6:0] field;
  } wss_slot_t;

  typedef struct packed {
    logic [6:0] id;
    logic start;
  } wss_effect_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_FETCH = 5'h02,
    ST_DECODE = 5'h04,
    ST_PLAY = 5'h08,
    ST_WAIT = 5'h10
  } wss_state_t;

endpackage : wss_pkg

// ---- logic/wss_slot_mem.sv ----
// Eight-entry slot store with one write port and two registered read ports.
// Assumes writes come from the bus side only; reads never stall.
`timescale 1ns/1ns
module wss_slot_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire wss_pkg::wss_slot_t wdata,
  input wire logic [2:0] raddr_bus,
  output wss_pkg::wss_slot_t rdata_bus,
  input wire logic [2:0] raddr_seq,
  output wss_pkg::wss_slot_t rdata_seq
);

  wss_pkg::wss_slot_t mem_reg [wss_pkg::SLOT_COUNT];

  // Storage; reset clears every slot so playback stops at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < wss_pkg::SLOT_COUNT; i++) begin
        mem_reg[i] <= wss_pkg::SLOT_RESET;
      end
    end else if (we) begin
      mem_reg[waddr] <= wdata;
    end
  end

  // Registered read ports; data one cycle after the address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_bus <= wss_pkg::SLOT_RESET;
      rdata_seq <= wss_pkg::SLOT_RESET;
    end else begin
      rdata_bus <= mem_reg[raddr_bus];
      rdata_seq <= mem_reg[raddr_seq];
    end
  end

endmodule : wss_slot_mem

// ---- verif/wss_props.sv ----
// Port checker for the slot sequencer.
// Assumes it is bound onto wss_sequencer with the same STEP_CYCLES.
`timescale 1ns/1ns
module wss_props #(
  parameter int unsigned STEP_CYCLES = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic seq_busy,
  input wire logic idle_active,
  input wire logic [2:0] cur_slot,
  input wire wss_pkg::wss_effect_t effect
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic go;
  int unsigned idle_cnt;
  // Start write without abort, accepted only while idle
  assign go = psel && penable && pwrite && paddr == {4'h0, wss_pkg::IDX_CONTROL, 2'b00} &&
              pwdata[wss_pkg::CTRL_START_BIT] && !pwdata[wss_pkg::CTRL_ABORT_BIT] && !seq_busy;
  // Length of the current idle stretch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) idle_cnt <= 0;
    else idle_cnt <= idle_active ? idle_cnt + 1 : 0;
  end
  chk_go_busy: assert property (go |=> seq_busy)
    else $error("start ignored");
  chk_go_first: assert property (go |=> cur_slot == 3'h0)
    else $error("start not at first slot");
  chk_delay_quiet: assert property (idle_active |-> !effect.start)
    else $error("effect during delay");
  chk_delay_busy: assert property (idle_active |-> seq_busy && $stable(cur_slot))
    else $error("delay outside its slot");
  chk_delay_len: assert property (idle_cnt <= 127 * STEP_CYCLES + 2)
    else $error("delay too long");
  chk_slot_step: assert property (seq_busy && $past(seq_busy) && cur_slot != $past(cur_slot)
    |-> cur_slot == $past(cur_slot) + 3'h1)
    else $error("slot skipped");
  chk_no_wrap: assert property (seq_busy && $past(seq_busy)
    |-> !(cur_slot == 3'h0 && $past(cur_slot) == 3'h7))
    else $error("ran past last slot");
  chk_start_id: assert property (effect.start |-> effect.id != 7'h00)
    else $error("zero entry played");
  chk_start_busy: assert property (effect.start |-> seq_busy && !idle_active)
    else $error("effect outside playback");
  cover property (effect.start);
  cover property (idle_active);
  cover property ($fell(seq_busy));
endmodule : wss_props

bind wss_sequencer wss_props #(.STEP_CYCLES(STEP_CYCLES)) u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .seq_busy(seq_busy), .idle_active(idle_active), .cur_slot(cur_slot),
  .effect(effect));

// ---- verif/tb.sv ----
// Bench for the slot sequencer: APB register tests and playback runs.
// Assumes a short STEP_CYCLES so delay slots finish quickly.
`timescale 1ns/1ns
module tb;
  localparam int unsigned STEP = 5;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, effect_done = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, idle_active, seq_busy, eq;
  logic [2:0] cur_slot;
  logic [7:0] rq;
  logic [7:0] sl [8];
  logic [1:0] rp [8];
  int err_count = 0, samples_checked = 0;
  wss_pkg::wss_effect_t effect;

  wss_sequencer #(.STEP_CYCLES(STEP)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .effect(effect), .effect_done(effect_done),
    .idle_active(idle_active), .seq_busy(seq_busy), .cur_slot(cur_slot));

  initial forever #50 pclk = ~pclk;

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask : chk

  // One APB transfer; held until pready is sampled high
  task automatic bus(input logic [5:0] i, input logic w, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {4'h0, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rq = prdata[7:0];
    eq = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : bus

  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    bus(i, 1'b0, 8'h00);
    chk("rdata", {24'h0, rq}, {24'h0, e});
  endtask : rd

  task automatic complete_run;
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // Load slots and repeats, start, then follow every entry as the engine would
  task automatic play;
    int n;
    for (int k = 0; k < 8; k++) bus(wss_pkg::IDX_SLOT_FIRST + 6'(k), 1'b1, sl[k]);
    bus(wss_pkg::IDX_REPEAT_LOW, 1'b1, {rp[3], rp[2], rp[1], rp[0]});
    bus(wss_pkg::IDX_REPEAT_HIGH, 1'b1, {rp[7], rp[6], rp[5], rp[4]});
    bus(wss_pkg::IDX_CONTROL, 1'b1, 8'h01);
    for (int k = 0; k < 8 && sl[k] != 8'h00; k++) begin
      for (int r = 0; r <= int'(rp[k]); r++) begin
        n = 0;
        if (sl[k][7]) begin
          while (idle_active !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
          end
          n = 0;
          while (idle_active === 1'b1) begin
            @(posedge pclk);
            n++;
          end
          chk("delay", n >= sl[k][6:0] * STEP && n <= sl[k][6:0] * STEP + 2, 1);
        end else begin
          while (effect.start !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
          end
          chk("id", effect.id, sl[k][6:0]);
          chk("slot", cur_slot, k);
          effect_done <= 1;
          @(posedge pclk);
          effect_done <= 0;
        end
      end
    end
    repeat (4) @(posedge pclk);
    chk("busy", seq_busy, 0);
  endtask : play

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rd(wss_pkg::IDX_SLOT_SEVEN, 8'h00);
    rd(wss_pkg::IDX_SLOT_EIGHT, 8'h00);
    bus(6'h3f, 1'b0, 8'h00);
    chk("slverr", eq, 1);
    // Full run: delays, boundary identifier, repeats on slot two and the last two slots
    sl = '{8'h05, 8'h82, 8'h11, 8'h22, 8'h33, 8'h44, 8'h83, 8'h7f};
    rp = '{default: 2'h0};
    rp[1] = 2'h3;
    rp[6] = 2'h2;
    rp[7] = 2'h1;
    play;
    rd(wss_pkg::IDX_SLOT_SEVEN, 8'h83);
    rd(wss_pkg::IDX_SLOT_EIGHT, 8'h7f);
    rd(wss_pkg::IDX_REPEAT_HIGH, 8'h60);
    // Stop marker in slot three; zero-length delay first
    sl = '{8'h80, 8'h06, 8'h00, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
    rp = '{default: 2'h0};
    rp[0] = 2'h1;
    play;
    rd(wss_pkg::IDX_REPEAT_LOW, 8'h01);
    // Abort in the middle of a delay; busy bit reads back before and after
    bus(wss_pkg::IDX_SLOT_FIRST, 1'b1, 8'h8a);
    bus(wss_pkg::IDX_CONTROL, 1'b1, 8'h01);
    rd(wss_pkg::IDX_CONTROL, 8'h01);
    chk("idle", idle_active, 1);
    bus(wss_pkg::IDX_CONTROL, 1'b1, 8'h02);
    rd(wss_pkg::IDX_CONTROL, 8'h00);
    chk("slot", cur_slot, 0);
    complete_run;
  end

  // Hang guard, far beyond the expected run length
  initial begin
    #(20000 * 100);
    err_count++;
    complete_run;
  end
endmodule : tb
